/* hdl/rail_seq_pkg.sv */
/*
 package for the rail enable sequencer: modes, widths, timing constants.
 assumes a 125 MHz system clock.
*/
package rail_seq_pkg;
   localparam int RAILS = 8;
   localparam int GPOS = 4;
   localparam int OUTS = RAILS + GPOS;
   localparam int VOLT_W = 10;
   localparam int DELAY_W = 12;
   localparam int CLK_HZ = 125000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 17;
   localparam int FLOAT_CYCLES = 4;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_TIME = 2'h1;
   localparam logic [1:0] MODE_PARENT_REG = 2'h2;
   localparam logic [1:0] MODE_PARENT_VOLT = 2'h3;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;
endpackage

/* hdl/ms_tick.sv */
/*
 millisecond tick divider: one-cycle pulse every period cycles.
 assumes a single clock and async active-high reset.
*/
`timescale 1ns/1ps
module ms_tick #(
   parameter int PERIOD = rail_seq_pkg::TICK_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_run,
   output logic o_tick
);
   initial begin
      if (PERIOD < 2 || PERIOD >= (1 << rail_seq_pkg::TICK_W)) begin
         $error("ms_tick period out of range");
      end
   end
   logic [rail_seq_pkg::TICK_W-1:0] count;
   wire wrap = (count == rail_seq_pkg::TICK_W'(PERIOD - 1));
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         count <= '0;
         o_tick <= 1'b0;
      end else if (!i_run) begin
         count <= '0;
         o_tick <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + 1'b1;
         o_tick <= wrap;
      end
   end
endmodule

/* hdl/rail_enable_sequencer.sv */
/*
 rail enable sequencer: eight rail enables and four general outputs,
 each released by one of four sequencing modes; rail health flags.
 assumes rail voltages arrive as sampled codes on the system clock and
 configuration ports are held steady by the surrounding logic.
*/
// Summary of operation
// - Eight rails, each a monitored voltage paired with one enable output.
// - Four general outputs use the same sequencing as rail enables.
// - Each rail has polarity, limits and time settings.
// - Rail in regulation only while voltage is between its two limits.
// - An output set to not sequenced is never asserted.
// - Time mode asserts the output after reset ends plus its delay.
// - Parent-regulation mode asserts after parent regulates plus the delay.
// - Parent-voltage mode asserts once parent voltage reaches the threshold.
// - Rail voltages and faults are monitored outside reset (flags held at zero in reset) and reported to host.
// - In reset outputs float first, then drive inactive, then sequence.
`timescale 1ns/1ps
module rail_enable_sequencer #(
   parameter int TICK_PERIOD = rail_seq_pkg::TICK_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [rail_seq_pkg::RAILS*rail_seq_pkg::VOLT_W-1:0] i_rail_volt,
   input wire logic [rail_seq_pkg::RAILS*rail_seq_pkg::VOLT_W-1:0] i_under_limit,
   input wire logic [rail_seq_pkg::RAILS*rail_seq_pkg::VOLT_W-1:0] i_over_limit,
   input wire logic [rail_seq_pkg::OUTS*2-1:0] i_seq_mode,
   input wire logic [rail_seq_pkg::OUTS*3-1:0] i_parent_sel,
   input wire logic [rail_seq_pkg::OUTS*rail_seq_pkg::DELAY_W-1:0] i_delay_ms,
   input wire logic [rail_seq_pkg::OUTS*rail_seq_pkg::VOLT_W-1:0] i_volt_thresh,
   input wire logic [rail_seq_pkg::OUTS-1:0] i_active_low,
   output logic [rail_seq_pkg::RAILS-1:0] o_rail_enable_out,
   output logic [rail_seq_pkg::RAILS-1:0] o_rail_enable_oe_n,
   output logic [rail_seq_pkg::GPOS-1:0] o_general_output,
   output logic [rail_seq_pkg::GPOS-1:0] o_general_output_oe_n,
   output logic [rail_seq_pkg::RAILS-1:0] o_in_regulation,
   output logic [rail_seq_pkg::RAILS-1:0] o_under_fault,
   output logic [rail_seq_pkg::RAILS-1:0] o_over_fault,
   output logic o_sequencing
);
   localparam int R = rail_seq_pkg::RAILS;
   localparam int N = rail_seq_pkg::OUTS;
   localparam int VW = rail_seq_pkg::VOLT_W;
   localparam int DW = rail_seq_pkg::DELAY_W;

   initial begin
      if (R != 8 || N != 12) begin
         $error("sequencer sized for eight rails and four general outputs");
      end
      if (TICK_PERIOD < 2 || TICK_PERIOD >= (1 << rail_seq_pkg::TICK_W)) begin
         $error("tick period does not fit the millisecond divider");
      end
   end

   typedef enum logic [2:0] {
      ST_FLOAT = 3'h1,
      ST_DRIVE = 3'h2,
      ST_RUN = 3'h4
   } phase_e;

   phase_e phase;
   phase_e next_phase;
   logic [2:0] float_count;
   logic [N-1:0] asserted;
   logic [DW-1:0] elapsed [N];
   wire tick;

   // drop a channel slice out of a flat bus
   function automatic logic [VW-1:0] volt_of(
      input logic [R*VW-1:0] bus,
      input int idx
   );
      volt_of = bus[idx*VW +: VW];
   endfunction

   // two-bit sequencing mode of one output
   function automatic logic [1:0] mode_of(
      input logic [N*2-1:0] modes,
      input int idx
   );
      mode_of = modes[idx*2 +: 2];
   endfunction

   // regulation window per rail
   // a rail sitting exactly on a limit still counts as regulated
   logic [R-1:0] reg_ok;
   logic [R-1:0] under;
   logic [R-1:0] over;
   always_comb begin
      for (int r = 0; r < R; r++) begin
         under[r] = volt_of(i_rail_volt, r) < volt_of(i_under_limit, r);
         over[r] = volt_of(i_rail_volt, r) > volt_of(i_over_limit, r);
         reg_ok[r] = !under[r] && !over[r];
      end
   end

   wire running = (phase == ST_RUN);

   // divider held cleared until run, so the first millisecond is whole
   ms_tick #(
      .PERIOD(TICK_PERIOD)
   ) u_tick (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_run(running),
      .o_tick(tick)
   );

   // per-output start condition and release decision
   logic [N-1:0] start_ok;
   logic [N-1:0] release_now;
   always_comb begin
      logic [1:0] mode;
      logic [2:0] par;
      logic [DW-1:0] dly;
      mode = 2'h0;
      par = 3'h0;
      dly = '0;
      for (int k = 0; k < N; k++) begin
         mode = mode_of(i_seq_mode, k);
         par = i_parent_sel[k*3 +: 3];
         dly = i_delay_ms[k*DW +: DW];
         case (mode)
            rail_seq_pkg::MODE_TIME: start_ok[k] = running;
            rail_seq_pkg::MODE_PARENT_REG: start_ok[k] = running && reg_ok[par];
            rail_seq_pkg::MODE_PARENT_VOLT:
               start_ok[k] = running &&
                  (volt_of(i_rail_volt, int'(par)) >= i_volt_thresh[k*VW +: VW]);
            default: start_ok[k] = 1'b0;
         endcase
         // threshold mode ignores the delay setting
         if (mode == rail_seq_pkg::MODE_PARENT_VOLT) begin
            release_now[k] = start_ok[k];
         end else begin
            release_now[k] = start_ok[k] && (elapsed[k] >= dly);
         end
      end
   end

   // float phase lets the board pulls settle before any pin is driven
   always_comb begin
      case (phase)
         ST_FLOAT: next_phase = (float_count == 3'(rail_seq_pkg::FLOAT_CYCLES - 1))
            ? ST_DRIVE : ST_FLOAT;
         ST_DRIVE: next_phase = ST_RUN;
         ST_RUN: next_phase = ST_RUN;
         default: next_phase = ST_FLOAT;
      endcase
   end

   // reset sequence: float, then drive inactive, then sequence
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         phase <= ST_FLOAT;
         float_count <= 3'h0;
      end else begin
         phase <= next_phase;
         float_count <= (phase == ST_FLOAT) ? float_count + 3'h1 : 3'h0;
      end
   end

   // millisecond counters; saturate so a long delay never wraps
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < N; k++) begin
            elapsed[k] <= rail_seq_pkg::DELAY_RESET;
         end
         asserted <= '0;
      end else begin
         for (int k = 0; k < N; k++) begin
            if (!start_ok[k]) begin
               elapsed[k] <= '0;
            end else if (tick && elapsed[k] != {DW{1'b1}}) begin
               elapsed[k] <= elapsed[k] + 1'b1;
            end
         end
         // released outputs stay asserted; mode none keeps them off
         for (int k = 0; k < N; k++) begin
            if (mode_of(i_seq_mode, k) == rail_seq_pkg::MODE_NONE) begin
               asserted[k] <= 1'b0;
            end else if (release_now[k]) begin
               asserted[k] <= 1'b1;
            end
         end
      end
   end

   // polarity applied last, so asserted always means supply on
   wire [N-1:0] pin_level = asserted ^ i_active_low;
   wire drive_en = (phase != ST_FLOAT);

   // pin stage: undriven until the float phase ends
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rail_enable_out <= '0;
         o_rail_enable_oe_n <= '1;
         o_general_output <= '0;
         o_general_output_oe_n <= '1;
      end else begin
         o_rail_enable_out <= drive_en ? pin_level[R-1:0] : '0;
         o_rail_enable_oe_n <= {R{!drive_en}};
         o_general_output <= drive_en ? pin_level[N-1:R] : '0;
         o_general_output_oe_n <= {rail_seq_pkg::GPOS{!drive_en}};
      end
   end

   // health flags follow the sampled codes by one cycle
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_in_regulation <= '0;
         o_under_fault <= '0;
         o_over_fault <= '0;
         o_sequencing <= 1'b0;
      end else begin
         o_in_regulation <= reg_ok;
         o_under_fault <= under;
         o_over_fault <= over;
         o_sequencing <= running;
      end
   end
endmodule

/* tb/rail_seq_props.sv */
/* port assertions for the rail enable sequencer.
 assumes it is bound into the design and config is held steady. */
`timescale 1ns/1ps
module rail_seq_props #(parameter int TICK_PERIOD = 10) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [79:0] i_rail_volt,
   input wire logic [79:0] i_under_limit,
   input wire logic [79:0] i_over_limit,
   input wire logic [23:0] i_seq_mode,
   input wire logic [11:0] i_active_low,
   input wire logic [7:0] o_rail_enable_out,
   input wire logic [7:0] o_rail_enable_oe_n,
   input wire logic [3:0] o_general_output,
   input wire logic [3:0] o_general_output_oe_n,
   input wire logic [7:0] o_in_regulation,
   input wire logic [7:0] o_under_fault,
   input wire logic [7:0] o_over_fault,
   input wire logic o_sequencing
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic [7:0] und, ovr, win;
   logic [11:0] none;
   wire [11:0] oe = {o_general_output_oe_n, o_rail_enable_oe_n};
   wire [11:0] pin = {o_general_output, o_rail_enable_out};
   wire [11:0] act = ~oe & (pin ^ i_active_low);
   always_comb begin
      for (int k = 0; k < 12; k++) begin
         none[k] = i_seq_mode[k*2+:2] == 2'h0;
         if (k < 8) begin
            und[k] = i_rail_volt[k*10+:10] < i_under_limit[k*10+:10];
            ovr[k] = i_rail_volt[k*10+:10] > i_over_limit[k*10+:10];
         end
      end
      win = ~und & ~ovr;
   end
   a_reg_window: assert property (!$past(i_rst) |-> o_in_regulation == $past(win))
      else $error("bad regulation flag");
   a_under_flag: assert property (!$past(i_rst) |-> o_under_fault == $past(und))
      else $error("bad under flag");
   a_over_flag: assert property (!$past(i_rst) |-> o_over_fault == $past(ovr))
      else $error("bad over flag");
   a_float_reset: assert property (disable iff (1'b0) i_rst |-> oe == 12'hFFF)
      else $error("pin driven in reset");
   a_float_hold: assert property ($fell(i_rst) |-> (oe == 12'hFFF) [*3])
      else $error("float phase short");
   a_drive_level: assert property (
      oe == 12'h000 && $past(oe) == 12'hFFF |-> pin == i_active_low)
      else $error("first level not inactive");
   a_none_quiet: assert property (
      (act & none & $past(none) & $past(none, 2) & $past(none, 3)) == 12'h000)
      else $error("unsequenced output on");
   a_latch_hold: assert property (
      !$past(i_rst) |-> ($past(act) & ~$past(none) & ~none & ~act) == 12'h000)
      else $error("output dropped");
   c_run: cover property ($rose(o_sequencing));
   c_lit: cover property (|(act & ~none));
   c_over: cover property (|o_over_fault);
endmodule
bind rail_enable_sequencer rail_seq_props #(.TICK_PERIOD(TICK_PERIOD)) props (.*);

/* tb/supply_model.sv */
/* supplies behind the enables: code ramps while enabled.
 assumes undriven enables are pulled to their inactive level. */
`timescale 1ns/1ps
module supply_model (
   input wire logic i_clk_sys,
   input wire logic [11:0] i_on,
   output logic [79:0] o_volt
);
   initial o_volt = '0;
   always @(posedge i_clk_sys) begin
      for (int r = 0; r < 8; r++) begin
         if (!i_on[r]) o_volt[r*10+:10] <= 10'h000;
         else if (o_volt[r*10+:10] < 10'h200) o_volt[r*10+:10] <= o_volt[r*10+:10] + 10'h010;
      end
   end
endmodule

/* tb/rail_enable_sequencer_tb.sv */
/* bench: supply model on the enables, config by ports, 10-cycle ms.
 assumes the checker is bound into the design. */
`timescale 1ns/1ps
module rail_enable_sequencer_tb;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b0;
   logic [79:0] volt;
   logic [79:0] under = {8{10'h180}};
   logic [79:0] over = {8{10'h280}};
   logic [23:0] mode = 24'h390139;
   logic [143:0] dly = {36'h0, 12'h003, 72'h0, 12'h001, 12'h002};
   logic [119:0] thr = {10'h0, 10'h3FF, 70'h0, 10'h100, 20'h0};
   logic [11:0] al = 12'h810;
   logic [7:0] en, en_oe, reg_ok, uf, of;
   logic [3:0] gp, gp_oe;
   logic seq;
   int num_errors = 0;
   int check_count = 0;
   int i;
   wire [11:0] oe = {gp_oe, en_oe};
   wire [11:0] pin = {gp, en};
   wire [11:0] act = ~oe & (pin ^ al);
   always #4 i_clk_sys = ~i_clk_sys;
   rail_enable_sequencer #(.TICK_PERIOD(10)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_rail_volt(volt), .i_under_limit(under), .i_over_limit(over), .i_seq_mode(mode),
      .i_parent_sel(36'h010000040), .i_delay_ms(dly), .i_volt_thresh(thr), .i_active_low(al),
      .o_rail_enable_out(en), .o_rail_enable_oe_n(en_oe), .o_general_output(gp),
      .o_general_output_oe_n(gp_oe), .o_in_regulation(reg_ok), .o_under_fault(uf),
      .o_over_fault(of), .o_sequencing(seq));
   supply_model sup (.i_clk_sys(i_clk_sys), .i_on(act), .o_volt(volt));
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   initial begin
      i_rst <= 1'b1; // a real edge at time zero, so the async reset branch runs
      repeat (16) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (i = 0; i < 12 && oe !== 12'h000; i++) step(1);
      check("float", 12'(i >= 4), 12'h001);
      check("first level", pin, al);
      for (i = 0; i < 12 && seq !== 1'b1; i++) step(1);
      check("sequencing", 12'(seq), 12'h001);
      step(10);
      check("delay 0", act, 12'h010);
      step(8);
      check("delay 2 early", act, 12'h010);
      step(8);
      check("delay 2", act & 12'h111, 12'h011);
      step(10);
      check("general delay 3", act, 12'h111);
      step(200);
      check("settled", act, 12'h317);
      check("regulation", reg_ok, 12'h017);
      check("under", uf, 12'h0E8);
      @(posedge i_clk_sys);
      over[9:0] <= 10'h1FF;
      under[19:10] <= 10'h200;
      mode[9:8] <= 2'h0;
      step(4);
      check("over", of, 12'h001);
      check("limit edge", reg_ok & 8'h03, 12'h002);
      check("unsequenced", act, 12'h307);
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      step(2);
      check("reset float", oe, 12'hFFF);
      check("reset sequencing", 12'(seq), 12'h000);
      end_of_test;
   end
   initial begin
      #20000;
      num_errors++;
      end_of_test;
   end
endmodule
